// ---- core/tpm_prescaler.sv ----
// Prescaler that turns the system clock into count clock enables.
`timescale 1ns/10ps
`default_nettype none
`include "tpm_defs.svh"
module tpm_prescaler
   import tpm_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic run,
   input wire logic [1:0] clk_sel,
   output logic div_tick
);
   logic [7:0] div_cnt;
   logic [7:0] next_div_cnt;
   logic next_div_tick;

   always_comb begin
      next_div_cnt = run ? div_cnt + 8'h01 : 8'h00;
      next_div_tick = 1'b0;
      if (run) begin
         case (tpm_clk_type'(clk_sel))
            TPM_CLK_FX: next_div_tick = 1'b1;
            TPM_CLK_DIV4: next_div_tick = (div_cnt[1:0] == `TPM_DIV4_LAST);
            TPM_CLK_DIV256: next_div_tick = (div_cnt == `TPM_DIV256_LAST);
            default: next_div_tick = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         div_cnt <= 8'h00;
         div_tick <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         div_tick <= next_div_tick;
      end
   end
endmodule : tpm_prescaler
`default_nettype wire

// ---- core/tpm_timer.sv ----
// Sixteen-bit timer with interval, pulse generator and capture modes behind AXI4-Lite.
//
// Our own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "tpm_defs.svh"
module tpm_timer
   import tpm_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] port_in,
   output logic [7:0] port_out,
   output logic [7:0] port_oe_n,
   output logic period_match_irq,
   output logic width_match_irq
);
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] tpm_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction : tpm_merge

   function automatic logic tpm_edge_ok(input logic [1:0] sel, input logic rise);
      logic ok;
      case (tpm_edge_type'(sel))
         TPM_EDGE_FALL: ok = !rise;
         TPM_EDGE_RISE: ok = rise;
         TPM_EDGE_BOTH: ok = 1'b1;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction : tpm_edge_ok

   ////////////////////////////////////////////////////////////////////////////////
   logic aw_held;
   logic [7:0] aw_addr;
   logic w_held;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic next_aw_held;
   logic [7:0] next_aw_addr;
   logic next_w_held;
   logic [31:0] next_w_data;
   logic [3:0] next_w_strb;
   logic next_bvalid;
   logic [1:0] next_bresp;
   logic next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;
   logic do_write;

   logic [7:0] dir;
   logic [7:0] latch;
   logic [1:0] mode;
   logic [2:0] ccc;
   logic [7:0] toc;
   logic [7:0] prm;
   logic [15:0] period;
   logic [15:0] width;
   logic [2:0] status;
   logic [15:0] count;
   logic tout;
   logic [7:0] next_dir;
   logic [7:0] next_latch;
   logic [1:0] next_mode;
   logic [2:0] next_ccc;
   logic [7:0] next_toc;
   logic [7:0] next_prm;
   logic [15:0] next_period;
   logic [15:0] next_width;
   logic [2:0] next_status;
   logic [15:0] next_count;
   logic next_tout;
   logic [7:0] next_port_out;
   logic next_pm_irq;
   logic next_wm_irq;

   logic [1:0] hist;
   logic [1:0] lvl;
   logic [1:0] next_hist;
   logic [1:0] next_lvl;
   logic [1:0] edge_seen;
   logic running;
   logic div_tick;
   logic sample_en;
   logic cnt_en;
   logic cap_a;
   logic cap_p;
   logic pmatch;
   logic wmatch;
   logic clear;
   logic ovf_ev;
   logic [31:0] wr_word;

   ////////////////////////////////////////////////////////////////////////////////
   // Its own channel must be empty and no response pending before a new address or data is taken, so a write
   // never overtakes its own response.
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign do_write = aw_held && w_held && !s_axi_bvalid;

   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held = w_held;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = s_axi_bvalid && !s_axi_bready;
      next_bresp = s_axi_bresp;
      next_rvalid = s_axi_rvalid && !s_axi_rready;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = (aw_addr[1:0] == 2'b00 && aw_addr <= `TPM_OFF_STATUS &&
                       aw_addr != `TPM_OFF_COUNT) ? `TPM_RESP_OKAY : `TPM_RESP_SLVERR;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp = `TPM_RESP_OKAY;
         case (s_axi_araddr[7:0])
            `TPM_OFF_DIR: next_rdata = {24'h000000, dir};
            `TPM_OFF_LATCH: next_rdata = {24'h000000, latch};
            `TPM_OFF_MODE: next_rdata = {30'h00000000, mode};
            `TPM_OFF_CCC: next_rdata = {29'h00000000, ccc};
            `TPM_OFF_TOC: next_rdata = {24'h000000, toc};
            `TPM_OFF_PRM: next_rdata = {24'h000000, prm};
            `TPM_OFF_PERIOD: next_rdata = {16'h0000, period};
            `TPM_OFF_WIDTH: next_rdata = {16'h0000, width};
            `TPM_OFF_COUNT: next_rdata = {16'h0000, count};
            `TPM_OFF_STATUS: next_rdata = {29'h00000000, status};
            default: begin
               next_rdata = 32'h00000000;
               next_rresp = `TPM_RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
         w_held <= 1'b0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TPM_RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `TPM_RESP_OKAY;
      end else begin
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held <= next_w_held;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   assign running = (tpm_mode_type'(mode) != TPM_STOP);

   tpm_prescaler u_prescaler (
      .clk(clk),
      .resetn(resetn),
      .run(running),
      .clk_sel(prm[`TPM_PRM_CLK]),
      .div_tick(div_tick)
   );

   // With an edge as count clock the inputs are sampled at the full clock rate.
   assign sample_en = (tpm_clk_type'(prm[`TPM_PRM_CLK]) == TPM_CLK_EDGE) ? running : div_tick;

   always_comb begin
      next_hist = hist;
      next_lvl = lvl;
      edge_seen = 2'b00;
      for (int i = 0; i < 2; i++) begin
         if (!running) begin
            // A level already present at restart must not count as an edge.
            next_hist[i] = port_in[i];
            next_lvl[i] = port_in[i];
         end else if (sample_en) begin
            next_hist[i] = port_in[i];
            if (port_in[i] == hist[i] && port_in[i] != lvl[i]) begin
               next_lvl[i] = port_in[i];
               edge_seen[i] = 1'b1;
            end
         end
      end
   end

   always_comb begin
      cap_a = edge_seen[`TPM_PIN_A] && ccc[`TPM_CCC_WCAP] &&
              tpm_edge_ok(prm[`TPM_PRM_EA], next_lvl[`TPM_PIN_A]);
      if (ccc[`TPM_CCC_PSRC]) begin
         cap_p = edge_seen[`TPM_PIN_A] && ccc[`TPM_CCC_PCAP] &&
                 tpm_edge_ok({prm[5], ~prm[4]}, next_lvl[`TPM_PIN_A]);
      end else begin
         cap_p = edge_seen[`TPM_PIN_B] && ccc[`TPM_CCC_PCAP] &&
                 tpm_edge_ok(prm[`TPM_PRM_EB], next_lvl[`TPM_PIN_B]);
      end
      if (tpm_clk_type'(prm[`TPM_PRM_CLK]) == TPM_CLK_EDGE) begin
         cnt_en = edge_seen[`TPM_PIN_A] &&
                  tpm_edge_ok(prm[`TPM_PRM_EA], next_lvl[`TPM_PIN_A]);
      end else begin
         cnt_en = div_tick;
      end
      cnt_en = cnt_en && running;
      pmatch = cnt_en && !ccc[`TPM_CCC_PCAP] && (count == period);
      wmatch = cnt_en && !ccc[`TPM_CCC_WCAP] && (count == width);
      clear = (tpm_mode_type'(mode) == TPM_CLEAR && pmatch) ||
              (tpm_mode_type'(mode) == TPM_RESTART && cap_a);
      // In clear mode without period capture, only a full-range period lets the counter reach the top and wrap.
      ovf_ev = cnt_en && (count == `TPM_CNT_MAX);
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      wr_word = 32'h00000000;
      next_dir = dir;
      next_latch = latch;
      next_mode = mode;
      next_ccc = ccc;
      next_toc = toc;
      next_prm = prm;
      next_period = period;
      next_width = width;
      next_status = status;
      next_count = count;
      next_tout = tout;
      if (do_write) begin
         case (aw_addr)
            `TPM_OFF_DIR: begin
               wr_word = tpm_merge({24'h000000, dir}, w_data, w_strb);
               next_dir = wr_word[7:0];
            end
            `TPM_OFF_LATCH: begin
               wr_word = tpm_merge({24'h000000, latch}, w_data, w_strb);
               next_latch = wr_word[7:0];
            end
            `TPM_OFF_MODE: begin
               wr_word = tpm_merge({30'h00000000, mode}, w_data, w_strb);
               next_mode = wr_word[1:0];
            end
            `TPM_OFF_CCC: begin
               wr_word = tpm_merge({29'h00000000, ccc}, w_data, w_strb);
               next_ccc = wr_word[2:0];
            end
            `TPM_OFF_TOC: begin
               wr_word = tpm_merge({24'h000000, toc}, w_data, w_strb);
               next_toc = wr_word[7:0];
            end
            `TPM_OFF_PRM: begin
               wr_word = tpm_merge({24'h000000, prm}, w_data, w_strb);
               next_prm = wr_word[7:0];
            end
            `TPM_OFF_PERIOD: begin
               wr_word = tpm_merge({16'h0000, period}, w_data, w_strb);
               next_period = wr_word[15:0];
            end
            `TPM_OFF_WIDTH: begin
               wr_word = tpm_merge({16'h0000, width}, w_data, w_strb);
               next_width = wr_word[15:0];
            end
            `TPM_OFF_STATUS: begin
               wr_word = tpm_merge(32'h00000000, w_data, w_strb);
               next_status = status & ~wr_word[2:0];
            end
            default: wr_word = 32'h00000000;
         endcase
      end
      // Captures win over a software write in the same cycle.
      if (cap_p) begin
         next_period = count;
      end
      if (cap_a) begin
         next_width = count;
      end
      if (ovf_ev) begin
         next_status[`TPM_ST_OVF] = 1'b1;
      end
      if (pmatch || cap_p) begin
         next_status[`TPM_ST_PM] = 1'b1;
      end
      if (wmatch || cap_a) begin
         next_status[`TPM_ST_WM] = 1'b1;
      end
      if (!running) begin
         next_count = 16'h0000;
         next_tout = `TPM_RST_TOUT;
      end else begin
         if (clear) begin
            next_count = 16'h0000;
         end else if (cnt_en) begin
            next_count = count + 16'h0001;
         end
         // High for width plus one counts, low for the rest of the period.
         if (toc[`TPM_TOC_EN] && toc[`TPM_TOC_WTOG] && wmatch) begin
            next_tout = !next_tout;
         end
         if (toc[`TPM_TOC_EN] && toc[`TPM_TOC_PTOG] && pmatch) begin
            next_tout = !next_tout;
         end
      end
      next_pm_irq = pmatch || cap_p;
      next_wm_irq = wmatch || cap_a;
      next_port_out = latch;
      next_port_out[`TPM_PIN_B] = latch[`TPM_PIN_B] | (toc[`TPM_TOC_EN] & tout);
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         dir <= `TPM_RST_DIR;
         latch <= `TPM_RST_BYTE;
         mode <= TPM_STOP;
         ccc <= 3'h0;
         toc <= `TPM_RST_BYTE;
         prm <= `TPM_RST_BYTE;
         period <= `TPM_RST_CMP;
         width <= `TPM_RST_CMP;
         status <= 3'h0;
         count <= 16'h0000;
         tout <= `TPM_RST_TOUT;
         hist <= 2'b00;
         lvl <= 2'b00;
         port_out <= `TPM_RST_BYTE;
         port_oe_n <= `TPM_RST_DIR;
         period_match_irq <= 1'b0;
         width_match_irq <= 1'b0;
      end else begin
         dir <= next_dir;
         latch <= next_latch;
         mode <= next_mode;
         ccc <= next_ccc;
         toc <= next_toc;
         prm <= next_prm;
         period <= next_period;
         width <= next_width;
         status <= next_status;
         count <= next_count;
         tout <= next_tout;
         hist <= next_hist;
         lvl <= next_lvl;
         port_out <= next_port_out;
         port_oe_n <= next_dir;
         period_match_irq <= next_pm_irq;
         width_match_irq <= next_wm_irq;
      end
   end
endmodule : tpm_timer
`default_nettype wire

// ---- inc/tpm_defs.svh ----
// Register offsets, field positions, reset values and counts of the timer block.
// How it works
// - Direction bit 0 drives pin, 1 floats.
// - Reset sets every direction bit to one.
// - Interval match clears counter and raises request.
// - Match interval is compare value plus one.
// - Overflow flag only when counter can wrap.
// - Two low prescaler bits pick count clock.
// - Edge codes: falling, rising, prohibited, both.
// - Pulse mode: period and width registers shape output.
// - Period N plus one; duty (M+1)/(N+1).
// - Measure by free-running count or restart.
// - Capture only after valid level seen twice.
// - Input A edge captures counter into width register.
`ifndef TPM_DEFS_SVH
`define TPM_DEFS_SVH
`define TPM_OFF_DIR 8'h00
`define TPM_OFF_LATCH 8'h04
`define TPM_OFF_MODE 8'h08
`define TPM_OFF_CCC 8'h0C
`define TPM_OFF_TOC 8'h10
`define TPM_OFF_PRM 8'h14
`define TPM_OFF_PERIOD 8'h18
`define TPM_OFF_WIDTH 8'h1C
`define TPM_OFF_COUNT 8'h20
`define TPM_OFF_STATUS 8'h24
`define TPM_RST_DIR 8'hFF
`define TPM_RST_BYTE 8'h00
`define TPM_RST_CMP 16'h0000
`define TPM_RST_TOUT 1'b1
`define TPM_CCC_PCAP 0
`define TPM_CCC_PSRC 1
`define TPM_CCC_WCAP 2
`define TPM_TOC_EN 0
`define TPM_TOC_PTOG 1
`define TPM_TOC_WTOG 4
`define TPM_PRM_CLK 1:0
`define TPM_PRM_EA 5:4
`define TPM_PRM_EB 7:6
`define TPM_ST_OVF 0
`define TPM_ST_PM 1
`define TPM_ST_WM 2
`define TPM_PIN_A 0
`define TPM_PIN_B 1
`define TPM_DIV4_LAST 8'h03
`define TPM_DIV256_LAST 8'hFF
`define TPM_CNT_MAX 16'hFFFF
`define TPM_RESP_OKAY 2'b00
`define TPM_RESP_SLVERR 2'b10
`endif

// ---- inc/tpm_pkg.sv ----
// Types shared by the timer block.
package tpm_pkg;
   typedef enum logic [1:0] {
      TPM_STOP = 2'b00,
      TPM_FREE = 2'b01,
      TPM_RESTART = 2'b10,
      TPM_CLEAR = 2'b11
   } tpm_mode_type;
   typedef enum logic [1:0] {
      TPM_CLK_FX = 2'b00,
      TPM_CLK_DIV4 = 2'b01,
      TPM_CLK_DIV256 = 2'b10,
      TPM_CLK_EDGE = 2'b11
   } tpm_clk_type;
   typedef enum logic [1:0] {
      TPM_EDGE_FALL = 2'b00,
      TPM_EDGE_RISE = 2'b01,
      TPM_EDGE_NONE = 2'b10,
      TPM_EDGE_BOTH = 2'b11
   } tpm_edge_type;
endpackage : tpm_pkg

// ---- test/test_timer16_interval_ppg_pulse_measure.sv ----
// Self-checking testbench of the timer block.
`timescale 1ns/10ps
`default_nettype none
`include "tpm_defs.svh"
module test_timer16_interval_ppg_pulse_measure
   import tpm_pkg::*;
;
   logic clk = 1'h0;
   logic resetn = 1'h0;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic period_match_irq, width_match_irq;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [7:0] port_in, port_out, port_oe_n;
   logic [7:0] src_level = 8'h00, src_en = 8'h00;
   int miscompares = 0, n_checks = 0, cyc = 0, wm_count = 0;

   tpm_timer dut (.clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .port_in, .port_out, .port_oe_n, .period_match_irq, .width_match_irq);
   tpm_pin_model pins (.port_out, .port_oe_n, .src_level, .src_en, .pin(port_in));

   always #4 clk = ~clk;
   // The longest scenario is a full 16-bit wrap, so the ceiling leaves room for it.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (width_match_irq === 1'h1) wm_count <= wm_count + 1;
      if (cyc == 90000) begin
         miscompares++;
         wrap_up();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      r = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask : wr
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      wr(a, d, r);
      check(r, `TPM_RESP_OKAY);
   endtask : w
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask : rd
   task automatic rdv(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      check(d, exp);
   endtask : rdv
   task automatic wait_pm(output int n);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (period_match_irq !== 1'h1);
   endtask : wait_pm
   task automatic seg(input logic lvl, output int n);
      n = 0;
      while (port_in[1] !== lvl) @(posedge clk);
      while (port_in[1] === lvl) begin
         @(posedge clk);
         n++;
      end
   endtask : seg
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      logic [31:0] d;
      logic [1:0] r;
      rdv(`TPM_OFF_DIR, 32'h000000FF);
      for (int a = 4; a <= 36; a += 4) begin
         rdv(a[7:0], 32'h0);
      end
      rd(8'h40, d, r);
      check(r, `TPM_RESP_SLVERR);
      wr(`TPM_OFF_COUNT, 32'h00001234, r);
      check(r, `TPM_RESP_SLVERR);
      rdv(`TPM_OFF_COUNT, 32'h0);
      w(`TPM_OFF_DIR, 32'hF0);
      w(`TPM_OFF_LATCH, 32'h05);
      rdv(`TPM_OFF_DIR, 32'hF0);
      check(port_oe_n, 8'hF0);
      check(port_in, 8'hF5);
      w(`TPM_OFF_LATCH, 32'h0);
      w(`TPM_OFF_DIR, 32'hFF);
   endtask : t_regs
   task automatic t_interval;
      int n;
      int div[3] = '{1, 4, 256};
      logic [31:0] d;
      logic [1:0] r;
      for (int s = 0; s < 3; s++) begin
         w(`TPM_OFF_CCC, 32'h0);
         w(`TPM_OFF_PERIOD, 32'h3);
         w(`TPM_OFF_PRM, s);
         w(`TPM_OFF_MODE, 32'h3);
         wait_pm(n);
         wait_pm(n);
         check(n, 4 * div[s]);
         w(`TPM_OFF_MODE, 32'h0);
      end
      rd(`TPM_OFF_STATUS, d, r);
      check(d[0], 1'h0);
      w(`TPM_OFF_PERIOD, 32'hFFFF);
      w(`TPM_OFF_PRM, 32'h0);
      w(`TPM_OFF_MODE, 32'h3);
      wait_pm(n);
      rd(`TPM_OFF_STATUS, d, r);
      check(d[0], 1'h1);
      w(`TPM_OFF_MODE, 32'h0);
      w(`TPM_OFF_STATUS, 32'h7);
      rdv(`TPM_OFF_STATUS, 32'h0);
   endtask : t_interval
   task automatic t_count;
      w(`TPM_OFF_PRM, 32'h2);
      w(`TPM_OFF_MODE, 32'h1);
      rdv(`TPM_OFF_COUNT, 32'h0);
      repeat (300) @(posedge clk);
      rdv(`TPM_OFF_COUNT, 32'h1);
      w(`TPM_OFF_MODE, 32'h0);
   endtask : t_count
   task automatic t_ppg;
      int hi, lo;
      w(`TPM_OFF_DIR, 32'hFD);
      w(`TPM_OFF_LATCH, 32'h0);
      w(`TPM_OFF_CCC, 32'h0);
      w(`TPM_OFF_PERIOD, 32'h40);
      w(`TPM_OFF_WIDTH, 32'h10);
      w(`TPM_OFF_TOC, 32'h13);
      w(`TPM_OFF_PRM, 32'h0);
      w(`TPM_OFF_MODE, 32'h3);
      seg(1'h0, lo);
      seg(1'h1, hi);
      seg(1'h0, lo);
      check(hi, 17);
      check(lo, 48);
      // Start just after a period match so the rewrite ends before the old width match.
      wait_pm(hi);
      w(`TPM_OFF_TOC, 32'h03);
      w(`TPM_OFF_WIDTH, 32'h20);
      @(posedge clk);
      w(`TPM_OFF_TOC, 32'h13);
      w(`TPM_OFF_STATUS, 32'h4);
      seg(1'h0, lo);
      seg(1'h1, hi);
      check(hi, 33);
      check(lo, 32);
      w(`TPM_OFF_MODE, 32'h0);
      w(`TPM_OFF_TOC, 32'h0);
   endtask : t_ppg
   task automatic t_capture;
      logic [31:0] c1, c2;
      logic [1:0] r;
      tpm_edge_type codes[4] = '{TPM_EDGE_FALL, TPM_EDGE_RISE, TPM_EDGE_NONE, TPM_EDGE_BOTH};
      int exp_n[4] = '{1, 1, 0, 2};
      int t0, n0;
      w(`TPM_OFF_DIR, 32'hFF);
      src_en <= 8'h01;
      w(`TPM_OFF_CCC, 32'h4);
      for (int i = 0; i < 4; i++) begin
         w(`TPM_OFF_PRM, {26'h0, codes[i], 4'h0});
         w(`TPM_OFF_MODE, 32'h1);
         n0 = wm_count;
         // A single-cycle spike must be swallowed by the input filter.
         src_level[0] <= 1'h1;
         @(posedge clk);
         src_level[0] <= 1'h0;
         repeat (6) @(posedge clk);
         src_level[0] <= 1'h1;
         t0 = cyc;
         repeat (10) @(posedge clk);
         rd(`TPM_OFF_WIDTH, c1, r);
         while (cyc < t0 + 40) @(posedge clk);
         src_level[0] <= 1'h0;
         repeat (10) @(posedge clk);
         rd(`TPM_OFF_WIDTH, c2, r);
         check(wm_count - n0, exp_n[i]);
         if (codes[i] == TPM_EDGE_BOTH) check(c2 - c1, 32'h28);
         rd(`TPM_OFF_STATUS, c1, r);
         check(c1[`TPM_ST_OVF], 1'h0);
         w(`TPM_OFF_STATUS, 32'h7);
         w(`TPM_OFF_MODE, 32'h0);
      end
      // Restart mode clears on each rising edge, so the capture is the gap minus one.
      w(`TPM_OFF_PRM, 32'h10);
      w(`TPM_OFF_MODE, 32'h2);
      src_level[0] <= 1'h1;
      repeat (20) @(posedge clk);
      src_level[0] <= 1'h0;
      repeat (20) @(posedge clk);
      src_level[0] <= 1'h1;
      repeat (10) @(posedge clk);
      rdv(`TPM_OFF_WIDTH, 32'h27);
      w(`TPM_OFF_MODE, 32'h0);
      src_en <= 8'h00;
   endtask : t_capture
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : wrap_up
   initial begin
      repeat (4) @(posedge clk);
      resetn <= 1'h1;
      t_regs();
      t_interval();
      t_count();
      t_ppg();
      t_capture();
      wrap_up();
   end
endmodule : test_timer16_interval_ppg_pulse_measure
`default_nettype wire

// ---- test/tpm_pin_model.sv ----
// Pulse sources and pull-ups on the shared timer pins.
`timescale 1ns/10ps
`default_nettype none
module tpm_pin_model (
   input wire logic [7:0] port_out,
   input wire logic [7:0] port_oe_n,
   input wire logic [7:0] src_level,
   input wire logic [7:0] src_en,
   output logic [7:0] pin
);
   // An undriven pin floats to its pull-up; the device wins any contention.
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!port_oe_n[i]) begin
            pin[i] = port_out[i];
         end else if (src_en[i]) begin
            pin[i] = src_level[i];
         end else begin
            pin[i] = 1'h1;
         end
      end
   end
endmodule : tpm_pin_model
`default_nettype wire

// ---- test/tpm_timer_properties.sv ----
// Concurrent checks on the bus, pin and request ports of the timer block.
`timescale 1ns/10ps
`default_nettype none
module tpm_timer_properties (
   input wire logic clk,
   input wire logic resetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [7:0] port_out,
   input wire logic [7:0] port_oe_n,
   input wire logic period_match_irq,
   input wire logic width_match_irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////////////////////
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence wr_answer;
      ##2 s_axi_bvalid;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   chk_reset_pins: assert property ($rose(resetn) |-> port_oe_n == 8'hFF && port_out == 8'h00)
      else $error("pins not in reset state");
   // The direction outputs may only move as a result of a register write.
   chk_dir_cause: assert property ($changed(port_oe_n) |-> s_axi_bvalid || $past(s_axi_bvalid))
      else $error("direction changed without a write");
   chk_wr_latency: assert property (wr_taken |-> wr_answer)
      else $error("write response not two cycles after request");
   chk_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data not one cycle after request");
   chk_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   chk_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
   chk_resp_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not released");
   chk_period_pulse: assert property (period_match_irq |=> !period_match_irq)
      else $error("period request longer than one cycle");
   chk_width_pulse: assert property (width_match_irq |=> !width_match_irq)
      else $error("width request longer than one cycle");
endmodule : tpm_timer_properties
bind tpm_timer tpm_timer_properties chk (.clk, .resetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .port_out, .port_oe_n, .period_match_irq, .width_match_irq);
`default_nettype wire
